//--- shared/pst_pkg.sv
package pst_pkg;
  // PWM counter geometry
  localparam int          PWM_MODULO        = 800;
  localparam int          PWM_CNT_W         = 10;
  localparam int          PWM_CHANNELS      = 6;
  localparam int          DUTY_W            = 10;
  localparam int          RELOADS_PER_SYNC  = 2;
  // Reset values
  localparam logic [9:0]  PWM_CNT_RESET     = 10'h000;
  localparam logic [9:0]  DUTY_RESET        = 10'h000;
  // Sampling timer
  localparam int          TMR_W             = 16;
  localparam logic [15:0] TMR_CMP_RESET     = 16'hffff;
  localparam logic [15:0] TMR_PRELOAD_RESET = 16'hffff;
  // Converter
  localparam int          RESULT_W          = 12;
  localparam int          SAMPLES_PER_SYNC  = 3;
  localparam int          SAMPLE_CNT_W      = 2;
  // Timing figures
  localparam int          CLK_PERIOD_NS     = 40;
  localparam int          FAST_LOOP_PERIOD_NS = 125000;
  localparam int          FAST_LOOP_PERIOD_CYC = FAST_LOOP_PERIOD_NS / CLK_PERIOD_NS;
endpackage

//--- hw/pst_event_flag.sv
`timescale 1ns/10ps
// Sticky event flag with interrupt gating; a set in the clear cycle survives
module pst_event_flag (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic irq_en_i,
  output logic      flag_o,
  output logic      irq_o
);
  typedef struct packed {
    logic flag;
  } pst_flag_state_type;

  pst_flag_state_type state;
  pst_flag_state_type next_state;

  // Set has priority so an event in the clear cycle is not lost
  always_comb begin
    next_state = state;
    if (clr_i) begin
      next_state.flag = 1'b0;
    end
    if (set_i) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Enabling while pending raises the request at once
  assign flag_o = state.flag;
  assign irq_o  = state.flag & irq_en_i;
endmodule

//--- hw/pst_sequencer.sv
`timescale 1ns/10ps
module pst_sequencer #(
  parameter int PWM_MODULO       = pst_pkg::PWM_MODULO,
  parameter int PWM_CHANNELS     = pst_pkg::PWM_CHANNELS,
  parameter int SAMPLES_PER_SYNC = pst_pkg::SAMPLES_PER_SYNC
) (
  input  wire logic                                            ref_clk_i,
  input  wire logic                                            rst_b_i,
  // Duty value write port
  input  wire logic                                            duty_wr_i,
  input  wire logic [PWM_CHANNELS*pst_pkg::DUTY_W-1:0]         pwm_duty_values_i,
  output logic [PWM_CHANNELS-1:0]                              pwm_out_o,
  output logic [pst_pkg::PWM_CNT_W-1:0]                        pwm_count_o,
  // Reload flag and interrupt
  input  wire logic                                            reload_flag_clr_i,
  input  wire logic                                            reload_irq_en_i,
  output logic                                                 reload_flag_o,
  output logic                                                 reload_irq_o,
  output logic                                                 reload_sync_o,
  // Sampling timer control
  input  wire logic                                            tmr_cmp_wr_i,
  input  wire logic [pst_pkg::TMR_W-1:0]                       tmr_cmp_i,
  input  wire logic                                            tmr_preload_wr_i,
  input  wire logic [pst_pkg::TMR_W-1:0]                       tmr_preload_i,
  input  wire logic                                            tmr_cnt_rst_i,
  input  wire logic                                            tmr_stop_i,
  input  wire logic                                            tmr_force_low_i,
  output logic                                                 timer_output_flag_o,
  output logic                                                 tmr_running_o,
  output logic [pst_pkg::TMR_W-1:0]                            tmr_count_o,
  output logic [pst_pkg::TMR_W-1:0]                            first_compare_reg_o,
  // Converter handshake
  output logic                                                 conv_start_o,
  input  wire logic                                            conv_done_i,
  input  wire logic [pst_pkg::RESULT_W-1:0]                    conv_data_i,
  output logic [pst_pkg::RESULT_W-1:0]                         first_result_reg_o,
  output logic [pst_pkg::SAMPLE_CNT_W-1:0]                     sample_count_o,
  // Scan-done flag and interrupt
  input  wire logic                                            scan_done_clr_i,
  input  wire logic                                            scan_irq_en_i,
  output logic                                                 scan_done_flag_o,
  output logic                                                 scan_irq_o,
  // Fault detection
  input  wire logic                                            over_current_i,
  input  wire logic                                            over_voltage_i,
  input  wire logic                                            fault_clr_i,
  input  wire logic                                            fault_irq_en_i,
  output logic                                                 fault_flag_o,
  output logic                                                 fault_irq_o
);
  localparam int CW = pst_pkg::PWM_CNT_W;
  localparam int DW = pst_pkg::DUTY_W;
  localparam int TW = pst_pkg::TMR_W;
  localparam int SW = pst_pkg::SAMPLE_CNT_W;
  localparam logic [CW-1:0] MOD_TOP   = CW'(PWM_MODULO);
  localparam logic [SW-1:0] SAMPLE_MAX = SW'(SAMPLES_PER_SYNC);
  localparam logic [0:0]    SYNC_PHASE = 1'(pst_pkg::RELOADS_PER_SYNC - 1);

  typedef struct packed {
    logic [CW-1:0]                   pwm_cnt;
    logic                            pwm_down;
    logic [0:0]                      reload_phase;
    logic                            reload_sync;
    logic [PWM_CHANNELS-1:0][DW-1:0] duty_buf;
    logic [PWM_CHANNELS-1:0][DW-1:0] duty_act;
    logic [PWM_CHANNELS-1:0]         pwm_out;
    logic                            tmr_run;
    logic [TW-1:0]                   tmr_cnt;
    logic [TW-1:0]                   tmr_cmp;
    logic [TW-1:0]                   tmr_preload;
    logic                            tflag;
    logic                            tflag_last;
    logic                            conv_start;
    logic                            conv_busy;
    logic [SW-1:0]                   sample_cnt;
    logic [pst_pkg::RESULT_W-1:0]    result;
  } pst_seq_state_type;

  pst_seq_state_type state;
  pst_seq_state_type next_state;

  logic reload_evt;
  logic tflag_rise;
  logic conv_finish;

  // Reload happens as the down-count lands on zero
  assign reload_evt  = state.pwm_down && (state.pwm_cnt == CW'(1));
  assign tflag_rise  = state.tflag && !state.tflag_last;
  assign conv_finish = state.conv_busy && conv_done_i;

  always_comb begin
    next_state = state;
    next_state.reload_sync = 1'b0;
    next_state.conv_start  = 1'b0;
    next_state.tflag_last  = state.tflag;

    // Center-aligned up/down counter
    if (!state.pwm_down) begin
      next_state.pwm_cnt = state.pwm_cnt + CW'(1);
      if (state.pwm_cnt == MOD_TOP - CW'(1)) begin
        next_state.pwm_down = 1'b1;
      end
    end else begin
      next_state.pwm_cnt = state.pwm_cnt - CW'(1);
      if (state.pwm_cnt == CW'(1)) begin
        next_state.pwm_down = 1'b0;
      end
    end

    // Software fills the buffer; the outputs only see it at reload
    if (duty_wr_i) begin
      next_state.duty_buf = pwm_duty_values_i;
    end
    if (reload_evt) begin
      next_state.duty_act = state.duty_buf;
      next_state.reload_phase = state.reload_phase + 1'b1;
      if (state.reload_phase == SYNC_PHASE) begin
        next_state.reload_sync = 1'b1;
      end
    end

    // Channel high while the counter sits below its duty value
    for (int k = 0; k < PWM_CHANNELS; k++) begin
      next_state.pwm_out[k] = (state.pwm_cnt < state.duty_act[k]);
    end

    // Sampling timer; the running counter advances each cycle
    if (state.tmr_run) begin
      next_state.tmr_cnt = state.tmr_cnt + TW'(1);
    end
    if (state.tmr_run && (state.tmr_cnt == state.tmr_cmp)) begin
      next_state.tmr_cmp = state.tmr_preload;
    end
    if (tmr_preload_wr_i) begin
      next_state.tmr_preload = tmr_preload_i;
    end
    if (tmr_cmp_wr_i) begin
      next_state.tmr_cmp = tmr_cmp_i;
    end
    if (tmr_cnt_rst_i) begin
      next_state.tmr_cnt = '0;
    end
    if (tmr_stop_i) begin
      next_state.tmr_run = 1'b0;
    end
    // Trigger beats a stop in the same cycle so no period is skipped
    if (state.reload_sync) begin
      next_state.tmr_run = 1'b1;
      next_state.tmr_cnt = '0;
    end

    // Output flag: a match wins over a forced low in the same cycle
    if (tmr_force_low_i) begin
      next_state.tflag = 1'b0;
    end
    if (state.tmr_run && (state.tmr_cnt == state.tmr_cmp)) begin
      next_state.tflag = 1'b1;
    end

    // Conversion start on the flag edge, capped per sync period
    if (tflag_rise && !state.conv_busy && (state.sample_cnt < SAMPLE_MAX)) begin
      next_state.conv_start = 1'b1;
      next_state.conv_busy  = 1'b1;
      next_state.sample_cnt = state.sample_cnt + SW'(1);
    end
    if (conv_finish) begin
      next_state.conv_busy = 1'b0;
      next_state.result    = conv_data_i;
    end
    // A fresh sync period starts counting samples again
    if (state.reload_sync) begin
      next_state.sample_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state              <= '0;
      state.pwm_cnt      <= pst_pkg::PWM_CNT_RESET;
      state.tmr_cmp      <= pst_pkg::TMR_CMP_RESET;
      state.tmr_preload  <= pst_pkg::TMR_PRELOAD_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Reload flag stays pending until software clears it
  pst_event_flag u_reload_flag (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .set_i     (reload_evt),
    .clr_i     (reload_flag_clr_i),
    .irq_en_i  (reload_irq_en_i),
    .flag_o    (reload_flag_o),
    .irq_o     (reload_irq_o)
  );

  pst_event_flag u_scan_flag (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .set_i     (conv_finish),
    .clr_i     (scan_done_clr_i),
    .irq_en_i  (scan_irq_en_i),
    .flag_o    (scan_done_flag_o),
    .irq_o     (scan_irq_o)
  );

  // Only a detected fault condition ever sets this flag
  pst_event_flag u_fault_flag (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .set_i     (over_current_i | over_voltage_i),
    .clr_i     (fault_clr_i),
    .irq_en_i  (fault_irq_en_i),
    .flag_o    (fault_flag_o),
    .irq_o     (fault_irq_o)
  );

  // Registered outputs
  assign pwm_out_o           = state.pwm_out;
  assign pwm_count_o         = state.pwm_cnt;
  assign reload_sync_o       = state.reload_sync;
  assign timer_output_flag_o = state.tflag;
  assign tmr_running_o       = state.tmr_run;
  assign tmr_count_o         = state.tmr_cnt;
  assign first_compare_reg_o = state.tmr_cmp;
  assign conv_start_o        = state.conv_start;
  assign first_result_reg_o  = state.result;
  assign sample_count_o      = state.sample_cnt;
endmodule

//--- test/pst_seq_chk.sv
`timescale 1ns/10ps
// Port-level checks on the sequencer; sees only top-level pins
module pst_seq_chk #(
  parameter int PWM_MODULO       = 800,
  parameter int SAMPLES_PER_SYNC = 3
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic [9:0]  pwm_count_o,
  input wire logic        reload_flag_o,
  input wire logic        reload_irq_en_i,
  input wire logic        reload_irq_o,
  input wire logic        reload_sync_o,
  input wire logic        tmr_running_o,
  input wire logic [15:0] tmr_count_o,
  input wire logic [15:0] first_compare_reg_o,
  input wire logic        timer_output_flag_o,
  input wire logic        conv_start_o,
  input wire logic [1:0]  sample_count_o,
  input wire logic        fault_flag_o,
  input wire logic        over_current_i,
  input wire logic        over_voltage_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_pwm_range; pwm_count_o <= PWM_MODULO; endproperty
  a_pwm_range: assert property (p_pwm_range) else $error("pwm counter above modulo");
  property p_pwm_turn;
    (pwm_count_o == PWM_MODULO - 1 && $past(pwm_count_o) == PWM_MODULO - 2) |=> pwm_count_o == PWM_MODULO;
  endproperty
  a_pwm_turn: assert property (p_pwm_turn) else $error("pwm counter misses modulo");
  property p_reload;
    (pwm_count_o == 10'h001 && $past(pwm_count_o) == 10'h002) |=> pwm_count_o == 10'h000 && reload_flag_o;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload flag at zero");
  property p_sync; reload_sync_o |-> pwm_count_o == 10'h000 && reload_flag_o; endproperty
  a_sync: assert property (p_sync) else $error("sync pulse away from reload");
  property p_sync_gap; reload_sync_o |=> !reload_sync_o [*8]; endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("sync pulse too long");
  property p_tmr_start; reload_sync_o |=> tmr_running_o && tmr_count_o == 16'h0000; endproperty
  a_tmr_start: assert property (p_tmr_start) else $error("timer not restarted at zero");
  property p_match; tmr_running_o && tmr_count_o == first_compare_reg_o |=> timer_output_flag_o; endproperty
  a_match: assert property (p_match) else $error("compare match without output flag");
  property p_conv; conv_start_o |-> $past(timer_output_flag_o) && !$past(timer_output_flag_o, 2); endproperty
  a_conv: assert property (p_conv) else $error("conversion start without flag edge");
  property p_count; sample_count_o <= SAMPLES_PER_SYNC; endproperty
  a_count: assert property (p_count) else $error("too many conversions");
  property p_irq; reload_irq_o == (reload_flag_o && reload_irq_en_i); endproperty
  a_irq: assert property (p_irq) else $error("reload interrupt mismatch");
  property p_fault; $rose(fault_flag_o) |-> $past(over_current_i || over_voltage_i); endproperty
  a_fault: assert property (p_fault) else $error("fault flag without fault");
endmodule
bind pst_sequencer pst_seq_chk #(.PWM_MODULO(PWM_MODULO), .SAMPLES_PER_SYNC(SAMPLES_PER_SYNC)) i_pst_seq_chk (
  .ref_clk_i, .rst_b_i, .pwm_count_o, .reload_flag_o, .reload_irq_en_i, .reload_irq_o, .reload_sync_o,
  .tmr_running_o, .tmr_count_o, .first_compare_reg_o, .timer_output_flag_o, .conv_start_o,
  .sample_count_o, .fault_flag_o, .over_current_i, .over_voltage_i);

//--- test/pst_amp_model.sv
`timescale 1ns/10ps
// Shunt amplifier and converter stand-in; answers each start after a short latency, or a long one with slow_i
module pst_amp_model (
  input  wire logic   ref_clk_i,
  input  wire logic   rst_b_i,
  input  wire logic   conv_start_i,
  input  wire logic   slow_i,
  output logic        conv_done_o,
  output logic [11:0] conv_data_o
);
  logic [5:0]  wait_cnt;
  logic        busy;
  logic [11:0] sample;
  // Result counts conversions, so a lost or extra start shows in the data
  // Each result stands for one active-vector shunt sample; phase mapping and zero sum are software work
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt    <= 6'h00;
      busy        <= 1'b0;
      conv_done_o <= 1'b0;
      sample      <= 12'h59f;
    end else begin
      conv_done_o <= 1'b0;
      if (conv_start_i) begin
        busy     <= 1'b1;
        wait_cnt <= slow_i ? 6'h28 : 6'h03;
      end else if (busy && wait_cnt == 6'h00) begin
        busy        <= 1'b0;
        conv_done_o <= 1'b1;
        sample      <= sample + 12'h001;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 6'h01;
      end
    end
  end
  // Data is only valid with done; otherwise the inverse, so a late read sees garbage
  assign conv_data_o = conv_done_o ? sample : ~sample;
endmodule

//--- test/pst_sequencer_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
`define WAIT(c, n) begin for (int w = 0; w < n && (c) !== 1'b1; w++) begin @(posedge ref_clk_i); #1; end if ((c) !== 1'b1) begin num_errors++; report_and_stop(); end end
module pst_sequencer_bench;
  logic        ref_clk_i, rst_b_i, duty_wr_i, reload_flag_clr_i, reload_irq_en_i, tmr_cmp_wr_i, tmr_preload_wr_i;
  logic        tmr_cnt_rst_i, tmr_stop_i, tmr_force_low_i, scan_done_clr_i, scan_irq_en_i, slow_i;
  logic        over_current_i, over_voltage_i, fault_clr_i, fault_irq_en_i, conv_done_i;
  logic        reload_flag_o, reload_irq_o, reload_sync_o, timer_output_flag_o, tmr_running_o, conv_start_o;
  logic        scan_done_flag_o, scan_irq_o, fault_flag_o, fault_irq_o;
  logic [59:0] pwm_duty_values_i;
  logic [15:0] tmr_cmp_i, tmr_preload_i, tmr_count_o, first_compare_reg_o;
  logic [11:0] conv_data_i, first_result_reg_o;
  logic [9:0]  pwm_count_o;
  logic [5:0]  pwm_out_o;
  logic [1:0]  sample_count_o;
  int          num_errors = 0;
  int          samples_checked = 0;
  pst_sequencer i_pst_sequencer (.ref_clk_i, .rst_b_i, .duty_wr_i, .pwm_duty_values_i, .pwm_out_o, .pwm_count_o,
    .reload_flag_clr_i, .reload_irq_en_i, .reload_flag_o, .reload_irq_o, .reload_sync_o, .tmr_cmp_wr_i, .tmr_cmp_i,
    .tmr_preload_wr_i, .tmr_preload_i, .tmr_cnt_rst_i, .tmr_stop_i, .tmr_force_low_i, .timer_output_flag_o,
    .tmr_running_o, .tmr_count_o, .first_compare_reg_o, .conv_start_o, .conv_done_i, .conv_data_i,
    .first_result_reg_o, .sample_count_o, .scan_done_clr_i, .scan_irq_en_i, .scan_done_flag_o, .scan_irq_o,
    .over_current_i, .over_voltage_i, .fault_clr_i, .fault_irq_en_i, .fault_flag_o, .fault_irq_o);
  pst_amp_model i_pst_amp_model (.ref_clk_i, .rst_b_i, .conv_start_i(conv_start_o), .slow_i,
    .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reload service: new duties, timer table start, counter reset, reload interrupt off
  task automatic reload_handler(input logic [59:0] duty);
    @(posedge ref_clk_i);
    {duty_wr_i, tmr_cmp_wr_i, tmr_preload_wr_i, tmr_cnt_rst_i, reload_flag_clr_i} <= 5'h1f;
    pwm_duty_values_i <= duty;
    tmr_cmp_i <= 16'h0064;
    tmr_preload_i <= 16'h012c;
    reload_irq_en_i <= 1'b0;
    @(posedge ref_clk_i);
    {duty_wr_i, tmr_cmp_wr_i, tmr_preload_wr_i, tmr_cnt_rst_i, reload_flag_clr_i} <= 5'h00;
    #1;
  endtask
  // Scan service: next table entry, output flag low, done flag cleared
  task automatic isr_ack(input logic [15:0] pre);
    @(posedge ref_clk_i);
    {tmr_preload_wr_i, tmr_force_low_i, scan_done_clr_i} <= 3'h7;
    tmr_preload_i <= pre;
    @(posedge ref_clk_i);
    {tmr_preload_wr_i, tmr_force_low_i, scan_done_clr_i} <= 3'h0;
    #1;
  endtask
  // Last sample handled: stop timer, swap interrupt enables; pending reload must fire at once
  task automatic stop_swap();
    @(posedge ref_clk_i);
    {tmr_stop_i, scan_irq_en_i, reload_irq_en_i} <= 3'h5;
    @(posedge ref_clk_i);
    tmr_stop_i <= 1'b0;
    #1;
    `CHK(reload_irq_o, 1'b1)
    `CHK(tmr_running_o, 1'b0)
  endtask
  // Outputs lag the counter by a cycle, so look one edge after the count is seen
  task automatic check_pwm(input logic [5:0] exp);
    `WAIT(pwm_count_o === 10'h0fa, 2000)
    @(posedge ref_clk_i);
    #1;
    `CHK(pwm_out_o, exp)
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {rst_b_i, duty_wr_i, reload_flag_clr_i, reload_irq_en_i, tmr_cmp_wr_i, tmr_preload_wr_i} = 6'h00;
    {tmr_cnt_rst_i, tmr_stop_i, tmr_force_low_i, scan_done_clr_i, scan_irq_en_i, slow_i} = 6'h00;
    {over_current_i, over_voltage_i, fault_clr_i, fault_irq_en_i} = 4'h0;
    {pwm_duty_values_i, tmr_cmp_i, tmr_preload_i} = '0;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    scan_irq_en_i <= 1'b1;
    fault_irq_en_i <= 1'b1;
    reload_handler({10'h226, 10'h1c2, 10'h15e, 10'h0fa, 10'h096, 10'h032});
    `WAIT(reload_flag_o, 1700)
    `CHK(reload_sync_o, 1'b0)
    `CHK(pwm_count_o, 10'h000)
    for (int p = 0; p < 2; p++) begin
      slow_i <= (p == 1);
      scan_irq_en_i <= 1'b1;
      `WAIT(reload_sync_o, 3300)
      for (int i = 0; i < 3; i++) begin
        `WAIT(scan_done_flag_o, 900)
        `CHK(scan_irq_o, 1'b1)
        `CHK(first_result_reg_o, 12'h5a0 + 12'(3 * p + i))
        if (i == 0) `CHK(first_compare_reg_o, 16'h012c)
        isr_ack(i == 0 ? 16'h01f4 : (i == 1 && p == 1 ? 16'h02bc : 16'hffff));
      end
      // Second pass leaves the timer on: a fourth match must not convert
      if (p == 1) begin
        `WAIT(tmr_count_o > 16'h02c6, 800)
        `CHK(timer_output_flag_o, 1'b1)
        `CHK(sample_count_o, 2'h3)
        `CHK(scan_done_flag_o, 1'b0)
      end
      stop_swap();
      reload_handler({10'h064, 10'h0c8, 10'h12c, 10'h190, 10'h1f4, 10'h258});
      if (p == 0) begin
        check_pwm(6'h38);
        check_pwm(6'h0f);
      end
    end
    `CHK(fault_flag_o, 1'b0)
    for (int f = 0; f < 2; f++) begin
      @(posedge ref_clk_i);
      over_current_i <= (f == 0);
      over_voltage_i <= (f == 1);
      @(posedge ref_clk_i);
      {over_current_i, over_voltage_i} <= 2'h0;
      @(posedge ref_clk_i);
      #1;
      `CHK(fault_irq_o, 1'b1)
      @(posedge ref_clk_i);
      fault_clr_i <= 1'b1;
      @(posedge ref_clk_i);
      fault_clr_i <= 1'b0;
      #1;
      `CHK(fault_flag_o, 1'b0)
    end
    report_and_stop();
  end
endmodule
